// ---- hdl/bridge_cfg_map.vh ----
// register offsets, field positions and reset values of the configuration header
`ifndef BRIDGE_CFG_MAP_VH
`define BRIDGE_CFG_MAP_VH
`define CFG_OFF_IDENT      8'h00
`define CFG_OFF_COMMAND    8'h04
`define CMD_IO_EN          0
`define CMD_MEM_EN         1
`define CMD_MASTER_EN      2
`define CMD_SPECIAL_CYC    3
`define CMD_MWI_EN         4
`define CMD_PALETTE_SNOOP  5
`define CMD_PARITY_RESP    6
`define CMD_WAIT_CTRL      7
`define CMD_SYSERR_EN      8
`define CMD_FAST_B2B       9
`define CMD_INT_DISABLE    10
`define CMD_RESET          16'h0000
`define STATUS_RESET       16'h0000
`define CFG_RD_RESET       32'h0000_0000
`define CFG_LANE_BITS      8
`define PALETTE_ADDR_MSB   9
`define CMD_WRITABLE_FWD   16'h0147
`define CMD_WRITABLE_REV   16'h0567
`define PALETTE_MASK_ADDR  10'h3C6
`define PALETTE_DATA_WADDR 10'h3C8
`define PALETTE_DATA_ADDR  10'h3C9
`define VENDOR_CODE        16'h1A2B
`define DEVICE_CODE        16'h3C4D
`endif

// ---- hdl/bridge_config_header_command.v ----
// configuration header identification and command register with its gating logic
//
// How it works
// - this layout is presented while the bridge runs in transparent mode
// - access kinds: read-only, read-write and write-one-clear; here only RO and RW occur
// - dword 0 bits 15:0 return a fixed vendor code; writes ignored
// - dword 0 bits 31:16 return a fixed device code
// - command bit 0 enables primary I/O decoding; resets to 0
// - command bit 1 enables primary memory decoding; resets to 0
// - bit 2 clear blocks primary mastering and secondary memory/I/O response
// - bit 2 set allows primary mastering; split completions bypass it in reverse mode
// - bit 3 reads zero; special cycles are never claimed
// - bit 4 reads zero; invalidate writes only forwarded, never originated
// - reverse mode bit 5 claims primary I/O writes to palette addresses
// - palette decode compares address bits 9:0 only, aliases match
// - bit 6 lets poisoned data or parity errors set the parity status flag
// - bit 7 reads zero; wait cycle control absent
// - bit 8 enables error messages forward or system error pin reverse
// - bit 9 reads zero; fast back-to-back not supported
// - reverse mode bit 10 holds all four interrupt lines deasserted
`timescale 1ns/1ps
`include "bridge_cfg_map.vh"

module bridge_config_header_command #(
  parameter [15:0] VENDOR_IDENTIFIER_VALUE = `VENDOR_CODE, // arbitrary value
  parameter [15:0] DEVICE_IDENTIFIER_VALUE = `DEVICE_CODE  // arbitrary value
) (
  input  wire        clk,
  input  wire        srst,
  input  wire        reverseMode,
  input  wire        cfgRead,
  input  wire        cfgWrite,
  input  wire [7:0]  cfgAddr,
  input  wire [3:0]  cfgByteEn,
  input  wire [31:0] cfgWrData,
  output reg  [31:0] cfgRdData,
  output reg         cfgRdValid,
  input  wire        priIoReq,
  input  wire        priIoWrite,
  input  wire [31:0] priIoAddr,
  input  wire        priMemReq,
  input  wire        secMemIoReq,
  input  wire        fwdMasterReq,
  input  wire        splitCplReq,
  input  wire        parityErrEvent,
  input  wire        errorEvent,
  input  wire [3:0]  intRequest,
  output wire        priIoClaim,
  output wire        priMemClaim,
  output wire        paletteClaim,
  output wire        secMemIoClaim,
  output wire        priMasterGrant,
  output wire        parityFlagSet,
  output wire        errMsgSend,
  output wire        sysErrAssert,
  output wire [3:0]  intAssert,
  output wire [15:0] commandValue
);

  // ==========================================================
  // sizes
  localparam CMD_WIDTH = 16;
  localparam INT_COUNT = 4;

  // ==========================================================
  // decoding helpers

  // a bit is writable only when its access kind is read-write in this mode
  function bitWritable;
    input [3:0]  bitIdx;
    input        reverse;
    reg   [15:0] mask;
    begin
      if (reverse) begin
        mask = `CMD_WRITABLE_REV;
      end else begin
        mask = `CMD_WRITABLE_FWD;
      end
      bitWritable = mask[bitIdx];
    end
  endfunction

  // byte enable lane that covers a given command bit
  function laneOn;
    input [3:0] bitIdx;
    input [3:0] byteEn;
    begin
      laneOn = byteEn[bitIdx / `CFG_LANE_BITS];
    end
  endfunction

  // whole-address match against a dword offset
  function offsetHit;
    input [7:0] addr;
    input [7:0] offset;
    begin
      offsetHit = (addr == offset);
    end
  endfunction

  // upper bits ignored on purpose so ISA aliases also hit
  function paletteHit;
    input [31:0] addr;
    reg   [9:0]  low;
    begin
      low        = addr[`PALETTE_ADDR_MSB:0];
      paletteHit = (low == `PALETTE_MASK_ADDR) ||
                   (low == `PALETTE_DATA_WADDR) ||
                   (low == `PALETTE_DATA_ADDR);
    end
  endfunction

  // ==========================================================
  // request decode
  wire cmdWrite;
  wire identRead;
  wire cmdRead;

  assign cmdWrite  = cfgWrite && offsetHit(cfgAddr, `CFG_OFF_COMMAND);
  assign identRead = cfgRead && offsetHit(cfgAddr, `CFG_OFF_IDENT);
  assign cmdRead   = cfgRead && offsetHit(cfgAddr, `CFG_OFF_COMMAND);

  // ==========================================================
  // command register
  reg  [15:0] command_q;
  wire [15:0] command_d;

  // one slice per bit; fixed bits never load, so they stay at their reset zero
  genvar i;
  generate
    for (i = 0; i < CMD_WIDTH; i = i + 1) begin : g_cmdBit
      localparam [3:0] BIT_IDX = i;
      wire bitRw;
      wire bitLoad;

      assign bitRw   = bitWritable(BIT_IDX, reverseMode);
      assign bitLoad = cmdWrite && laneOn(BIT_IDX, cfgByteEn) && bitRw;
      // reverse-only bits drop back to zero on the first clock edge after the mode turns forward
      assign command_d[i] = bitLoad ? cfgWrData[i] : (command_q[i] && bitRw);
    end
  endgenerate

  always @(posedge clk) begin
    if (srst) begin
      command_q <= `CMD_RESET;
    end else begin
      command_q <= command_d;
    end
  end

  // ==========================================================
  // read path; identification is constant so writes to dword 0 fall away
  reg [31:0] readWord;

  always @* begin
    readWord = `CFG_RD_RESET;
    if (identRead) begin
      readWord = {DEVICE_IDENTIFIER_VALUE, VENDOR_IDENTIFIER_VALUE};
    end else if (cmdRead) begin
      readWord = {`STATUS_RESET, command_q}; // status half left out
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      cfgRdData  <= `CFG_RD_RESET;
      cfgRdValid <= 1'b0;
    end else begin
      cfgRdValid <= cfgRead;
      if (cfgRead) begin
        cfgRdData <= readWord;
      end
    end
  end

  // ==========================================================
  // enables taken from the command register
  wire ioEnable;
  wire memEnable;
  wire masterEnable;
  wire snoopEnable;
  wire parityEnable;
  wire errorEnable;
  wire intBlocked;

  assign ioEnable     = command_q[`CMD_IO_EN];
  assign memEnable    = command_q[`CMD_MEM_EN];
  assign masterEnable = command_q[`CMD_MASTER_EN];
  assign snoopEnable  = reverseMode && command_q[`CMD_PALETTE_SNOOP];
  assign parityEnable = command_q[`CMD_PARITY_RESP];
  assign errorEnable  = command_q[`CMD_SYSERR_EN];
  assign intBlocked   = reverseMode && command_q[`CMD_INT_DISABLE];

  // ==========================================================
  // primary target decoding
  assign priIoClaim   = priIoReq && ioEnable;
  assign priMemClaim  = priMemReq && memEnable;
  assign paletteClaim = snoopEnable &&
                        priIoReq &&
                        priIoWrite &&
                        paletteHit(priIoAddr);

  // ==========================================================
  // mastering
  // in reverse mode split completions skip the master enable so replies are never stalled
  assign secMemIoClaim  = secMemIoReq && masterEnable;
  assign priMasterGrant = (fwdMasterReq && masterEnable) ||
                          (splitCplReq && reverseMode);

  // ==========================================================
  // error reporting
  assign parityFlagSet = parityErrEvent && parityEnable;
  assign errMsgSend    = errorEvent && errorEnable && !reverseMode;
  assign sysErrAssert  = errorEvent && errorEnable && reverseMode;

  // ==========================================================
  // legacy interrupts, one gate per line
  genvar k;
  generate
    for (k = 0; k < INT_COUNT; k = k + 1) begin : g_intLine
      assign intAssert[k] = intRequest[k] && !intBlocked;
    end
  endgenerate

  // ==========================================================
  // register view
  assign commandValue = command_q;

endmodule // bridge_config_header_command

// ---- bench/cfg_host.sv ----
// configuration requester model
`timescale 1ns/1ps
module cfg_host (
  input  wire         clk,
  output logic        rd,
  output logic        wr,
  output logic [7:0]  a,
  output logic [3:0]  be,
  output logic [31:0] d
);
  initial {rd, wr, a, be, d} = '0;
  // released address and data lines show the inverse so a stale value is never taken
  task op(input logic w, input logic [7:0] ad, input logic [3:0] b, input logic [31:0] v);
    @(negedge clk);
    {rd, wr, a, be, d} = {!w, w, ad, b, v};
    @(negedge clk);
    {rd, wr, a, d} = {2'b00, ~ad, ~v};
  endtask
endmodule // cfg_host

// ---- bench/cmd_checker_assertions.sv ----
// command register assertions
`timescale 1ns/1ps
module cmd_checker (
  input wire        clk,
  input wire        srst,
  input wire        reverseMode,
  input wire        cfgRead,
  input wire        cfgWrite,
  input wire        cfgRdValid,
  input wire        priIoReq,
  input wire        priIoClaim,
  input wire [7:0]  cfgAddr,
  input wire [3:0]  cfgByteEn,
  input wire [3:0]  intRequest,
  input wire [3:0]  intAssert,
  input wire [31:0] cfgWrData,
  input wire [15:0] commandValue
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  sequence cmdWr; cfgWrite && cfgAddr == 8'h04 && cfgByteEn[0]; endsequence
  ro_bits_a: assert property (
    (commandValue & 16'hFA98) == 16'h0000)
    else $error("fixed bit");
  fwd_zero_a: assert property (
    !reverseMode |=> (commandValue & 16'h0420) == 16'h0000)
    else $error("fwd");
  lo_write_a: assert property (
    cmdWr |=> commandValue[2:0] == $past(cfgWrData[2:0]))
    else $error("wr");
  cmd_hold_a: assert property (
    !cfgWrite && reverseMode |=> $stable(commandValue))
    else $error("hold");
  cmd_reset_a: assert property (
    disable iff (1'b0) srst |=> commandValue == 16'h0000)
    else $error("rst");
  rd_valid_a: assert property (
    1 |=> cfgRdValid == $past(cfgRead))
    else $error("valid");
  io_gate_a: assert property (
    priIoClaim == (priIoReq && commandValue[0]))
    else $error("io");
  int_mask_a: assert property (
    intAssert == ((reverseMode && commandValue[10]) ? 4'h0 : intRequest))
    else $error("int");
endmodule // cmd_checker
bind bridge_config_header_command cmd_checker cmd_checker_i (.*);

// ---- bench/bridge_config_header_command_bench.sv ----
// self-checking bench for the command register
`timescale 1ns/1ps
`include "bridge_cfg_map.vh"
module bridge_config_header_command_bench;
  logic clk = 0, srst = 1, rev = 0;
  logic [8:0] ev = 0;
  logic [31:0] ioAddr = 32'h0000_F3C8;
  int error_cnt = 0, compares = 0, cyc = 0;
  wire rd, wr, vld;
  wire [7:0] a, o;
  wire [3:0] be, ia;
  wire [31:0] d, q;
  wire [15:0] cv;
  initial forever #2.5 clk = ~clk;
  always @(posedge clk) if (++cyc == 3000) begin
    error_cnt++;
    wrap_up;
  end
  cfg_host cfg_host_i (.clk(clk), .rd(rd), .wr(wr), .a(a), .be(be), .d(d));
  // address is an alias of a palette port, so upper bits must be ignored
  bridge_config_header_command bridge_config_header_command_i (.clk(clk), .srst(srst),
    .reverseMode(rev), .cfgRead(rd), .cfgWrite(wr), .cfgAddr(a), .cfgByteEn(be),
    .cfgWrData(d), .cfgRdData(q), .cfgRdValid(vld), .priIoReq(ev[0]), .priIoWrite(ev[1]),
    .priIoAddr(ioAddr), .priMemReq(ev[2]), .secMemIoReq(ev[3]), .fwdMasterReq(ev[4]),
    .splitCplReq(ev[5]), .parityErrEvent(ev[6]), .errorEvent(ev[7]), .intRequest({4{ev[8]}}),
    .priIoClaim(o[7]), .priMemClaim(o[6]), .paletteClaim(o[5]), .secMemIoClaim(o[4]),
    .priMasterGrant(o[3]), .parityFlagSet(o[2]), .errMsgSend(o[1]), .sysErrAssert(o[0]),
    .intAssert(ia), .commandValue(cv));
  task chk(input logic [31:0] s, e);
    compares++;
    if (s !== e) begin
      error_cnt++;
      $display("MISMATCH %0t saw %h want %h", $time, s, e);
    end
  endtask
  task wrap_up;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task t_ident;
    cfg_host_i.op(0, 8'h00, 4'hF, 0);
    chk(vld, 1);
    chk(q, {`DEVICE_CODE, `VENDOR_CODE});
    cfg_host_i.op(1, 8'h00, 4'hF, 32'hFFFFFFFF);
    cfg_host_i.op(0, 8'h00, 4'hF, 0);
    chk(q, {`DEVICE_CODE, `VENDOR_CODE});
  endtask
  task t_fwd;
    ev = 9'h1FF;
    cfg_host_i.op(1, 8'h04, 4'h3, 32'h0000FFFF);
    chk(cv, 16'h0147);
    chk({o, ia}, 12'hDEF);
    cfg_host_i.op(0, 8'h04, 4'h3, 0);
    chk(q, 32'h00000147);
    cfg_host_i.op(1, 8'h04, 4'h3, 0);
    chk({o, ia}, 12'h00F);
  endtask
  task t_rev;
    rev = 1;
    cfg_host_i.op(1, 8'h04, 4'h3, 32'h0000FFFF);
    chk(cv, 16'h0567);
    chk({o, ia}, 12'hFD0);
    cfg_host_i.op(1, 8'h04, 4'h1, 0);
    chk({cv, o, ia}, 28'h0500090);
    rev = 0;
    @(negedge clk);
    chk({cv, o, ia}, 28'h010002F);
  endtask
  task t_palette;
    rev = 1;
    ev = 9'h003;
    cfg_host_i.op(1, 8'h04, 4'h1, 32'h0000_0020);
    chk(cv, 16'h0120);
    chk(o[5], 1);
    ioAddr = 32'h0000_07C9;
    #1 chk(o[5], 1);
    ioAddr = 32'hABCD_03C6;
    #1 chk(o[5], 1);
    ioAddr = 32'h0000_03C7;
    #1 chk(o[5], 0);
    ioAddr = 32'h0000_03C8;
    ev = 9'h001;
    #1 chk(o[5], 0);
    ev = 9'h003;
    rev = 0;
    #1 chk(o[5], 0);
    @(negedge clk);
    chk(cv, 16'h0100);
    cfg_host_i.op(1, 8'h04, 4'h2, 32'h0000_00FF);
    chk(cv, 16'h0000);
    cfg_host_i.op(0, 8'h08, 4'hF, 0);
    chk(vld, 1);
    chk(q, 0);
  endtask
  task t_reset;
    cfg_host_i.op(1, 8'h04, 4'h3, 32'h0000_FFFF);
    chk(cv, 16'h0147);
    @(negedge clk);
    srst = 1;
    @(negedge clk);
    srst = 0;
    chk(cv, 16'h0000);
    chk(vld, 0);
    chk(q, 0);
  endtask
  initial begin
    repeat (8) @(negedge clk);
    srst = 0;
    chk(cv, 0);
    chk(q, 0);
    t_ident;
    t_fwd;
    t_rev;
    t_palette;
    t_reset;
    wrap_up;
  end
endmodule // bridge_config_header_command_bench
